// ==== design/aicr_pkg.sv ====
package aicr_pkg;

    // -------------------------------------------------------------
    // register indices and byte addresses (address = index * 4)
    // -------------------------------------------------------------
    localparam int unsigned IDX_VENDOR_CODE  = 'h100;
    localparam int unsigned IDX_PART_CODE    = 'h102;
    localparam int unsigned IDX_COMMAND      = 'h104;
    localparam int unsigned IDX_STATUS       = 'h106;
    localparam int unsigned IDX_HEADER       = 'h10e;
    localparam int unsigned IDX_PRIMARY_TIM  = 'h140;
    localparam int unsigned IDX_SECONDARY    = 'h144;
    localparam int unsigned IDX_IRQ_STATUS   = 'h160;
    localparam int unsigned IDX_IRQ_MASK     = 'h164;

    localparam logic [11:0] ADDR_VENDOR_CODE = 12'(IDX_VENDOR_CODE * 4);
    localparam logic [11:0] ADDR_PART_CODE   = 12'(IDX_PART_CODE * 4);
    localparam logic [11:0] ADDR_COMMAND     = 12'(IDX_COMMAND * 4);
    localparam logic [11:0] ADDR_STATUS      = 12'(IDX_STATUS * 4);
    localparam logic [11:0] ADDR_HEADER      = 12'(IDX_HEADER * 4);
    localparam logic [11:0] ADDR_PRIMARY_TIM = 12'(IDX_PRIMARY_TIM * 4);
    localparam logic [11:0] ADDR_SECONDARY   = 12'(IDX_SECONDARY * 4);
    localparam logic [11:0] ADDR_IRQ_STATUS  = 12'(IDX_IRQ_STATUS * 4);
    localparam logic [11:0] ADDR_IRQ_MASK    = 12'(IDX_IRQ_MASK * 4);

    // -------------------------------------------------------------
    // reset values and constants
    // -------------------------------------------------------------
    localparam logic [15:0] RST_COMMAND      = 16'h0000;
    localparam logic [15:0] RST_PRIMARY_TIM  = 16'h0000;
    localparam logic [3:0]  RST_SECONDARY    = 4'h0;
    localparam logic [2:0]  RST_IRQ_MASK     = 3'h0;
    localparam logic [7:0]  HEADER_FORMAT    = 8'h00;
    localparam logic [1:0]  SEL_TIMING_CODE  = 2'h1;
    localparam logic [1:0]  AXI_RESP_OKAY    = 2'h0;

    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int unsigned CMD_ENABLE_BIT   = 0;
    localparam int unsigned STS_SEL_LSB      = 9;
    localparam int unsigned STS_ABORT_LSB    = 11;
    localparam int unsigned PT_FAST_BANK     = 0;
    localparam int unsigned PT_READY_EN      = 1;
    localparam int unsigned PT_PREFETCH      = 2;
    localparam int unsigned PT_COMPAT        = 3;
    localparam int unsigned PT_DRIVE1_SHIFT  = 4;
    localparam int unsigned PT_RECOVERY_LSB  = 8;
    localparam int unsigned PT_SAMPLE_LSB    = 12;
    localparam int unsigned PT_SPLIT_BIT     = 14;
    localparam int unsigned PT_DECODE_BIT    = 15;
    localparam int unsigned SEC_RECOVERY_LSB = 0;
    localparam int unsigned SEC_SAMPLE_LSB   = 2;
    localparam logic [15:0] PT_WRITE_MASK    = 16'hf3ff;
    localparam logic [2:0]  RECOVERY_BASE    = 3'h4;
    localparam logic [2:0]  SAMPLE_BASE      = 3'h5;

    // per-drive timing set handed to the strobe generator
    typedef struct packed {
        logic       compat_timing;
        logic       prefetch_en;
        logic       ready_en;
        logic       fast_bank;
        logic [2:0] sample_clks;
        logic [2:0] recovery_clks;
    } aicr_drive_t;

endpackage : aicr_pkg

// ==== design/aicr_regs.sv ====
// Function
// [RQ1] vendor code reads a fixed 16-bit identity; writes ignored
// [RQ2] part code reads a fixed 16-bit identity; writes ignored
// [RQ3] software keeps command bit 0, interface enable, at one
// [RQ4] software writes command bits 15:1 only with reset value
// [RQ5] status bits 10:9 always read binary 01
// [RQ6] status bit 11 sets when interface signals an abort
// [RQ7] status bit 12 sets when interface receives a target abort
// [RQ8] status bit 13 sets when interface generates a master abort
// [RQ9] abort flags unaffected by reads; writing one clears, zero keeps
// [RQ10] software writes status reserved bits only with reset values
// [RQ11] software does not touch the drive control register set
// [RQ12] latency, bus-master address and ultra dma locations are reserved
// [RQ13] header format reads constant: type 0, single function
// [RQ14] recovery code 00..11 gives four down to one idle clocks
// [RQ15] ready sample code 00..11 gives five down to two clocks
// [RQ16] split enable gives drive 1 the secondary timing settings
// [RQ17] unmapped offsets read zero and ignore writes
//
// Implementation choice: the AXI4-Lite interface to the registers.
module aicr_regs
    import aicr_pkg::*;
#(
    parameter int          ADDR_W      = 12,
    parameter logic [15:0] VENDOR_CODE = 16'h1a2b,  // arbitrary value
    parameter logic [15:0] PART_CODE   = 16'h3c4d   // arbitrary value
) (
    input  wire logic              core_clk_i,
    input  wire logic              srst_i,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    // abort events from the interface core, one-cycle pulses
    input  wire logic              signaled_abort_i,
    input  wire logic              abort_in_i,
    input  wire logic              master_abort_i,
    // settings to the strobe generator, and the interrupt
    output logic                   interface_enable_o,
    output logic                   decode_enable_o,
    output aicr_drive_t            drive0_timing_o,
    output aicr_drive_t            drive1_timing_o,
    output logic                   irq_o
);

    // -------------------------------------------------------------
    // elaboration checks
    // -------------------------------------------------------------
    if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
        $error("aicr_regs: ADDR_W must lie between 12 and 32");
    end

    // -------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------
    logic              awready_reg;
    logic              wready_reg;
    logic              bvalid_reg;
    logic              aw_held_reg;
    logic              w_held_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0]       w_data_reg;
    logic [3:0]        w_strb_reg;
    logic              arready_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [15:0]       command_reg;
    logic [15:0]       primary_reg;
    logic [3:0]        secondary_reg;
    logic [2:0]        irq_mask_reg;
    logic              irq_reg;
    logic              enable_reg;
    logic              decode_reg;
    aicr_drive_t       drive0_reg;
    aicr_drive_t       drive1_reg;
    logic [2:0]        abort_flags;
    logic [2:0]        irq_flags;
    logic [2:0]        events;
    logic [2:0]        abort_clr;
    logic [2:0]        irq_clr;
    logic              wr_fire;
    logic              rd_fire;
    logic [15:0]       wmask;
    logic [15:0]       wr_data16;
    logic [31:0]       rdata_next;
    logic              rd_hit_irq;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [11:0] c);
        return {a[ADDR_W-1:2], 2'b00} == ADDR_W'(c);
    endfunction : is_addr

    // low code means the slowest setting, so subtract from the base
    function automatic logic [2:0] to_clks(input logic [2:0] base, input logic [1:0] code);
        return base - {1'b0, code};
    endfunction : to_clks

    // -------------------------------------------------------------
    // write channel
    // -------------------------------------------------------------
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wmask   = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

    // address and data are taken in any order, one write at a time
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
        end else begin
            if (s_axi_awvalid_i && awready_reg) begin
                awready_reg <= 1'b0;
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && wready_reg) begin
                wready_reg <= 1'b0;
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_i;
                w_strb_reg <= s_axi_wstrb_i;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
            end
            // reopen only after the response is taken
            if (bvalid_reg && s_axi_bready_i) begin
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    // write response, always okay: unmapped writes simply vanish
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            bvalid_reg <= 1'b0;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
        end else if (s_axi_bready_i) begin
            bvalid_reg <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // writable registers
    // -------------------------------------------------------------
    assign wr_data16 = w_data_reg[15:0];

    // identity and reserved offsets have no write path at all
    always_ff @(posedge core_clk_i) begin  // see [RQ1] see [RQ2] see [RQ17]
        if (srst_i) begin
            command_reg   <= RST_COMMAND;
            primary_reg   <= RST_PRIMARY_TIM;
            secondary_reg <= RST_SECONDARY;
            irq_mask_reg  <= RST_IRQ_MASK;
        end else if (wr_fire) begin
            if (is_addr(aw_addr_reg, ADDR_COMMAND)) begin
                command_reg <= (command_reg & ~wmask) | (wr_data16 & wmask);
            end
            if (is_addr(aw_addr_reg, ADDR_PRIMARY_TIM)) begin
                primary_reg <= ((primary_reg & ~wmask) | (wr_data16 & wmask)) & PT_WRITE_MASK;
            end
            if (is_addr(aw_addr_reg, ADDR_SECONDARY) && w_strb_reg[0]) begin
                secondary_reg <= w_data_reg[3:0];
            end
            if (is_addr(aw_addr_reg, ADDR_IRQ_MASK) && w_strb_reg[0]) begin
                irq_mask_reg <= w_data_reg[2:0];
            end
        end
    end

    // -------------------------------------------------------------
    // abort flags and interrupt status
    // -------------------------------------------------------------
    assign events = {master_abort_i, abort_in_i, signaled_abort_i};  // see [RQ6] see [RQ7] see [RQ8]

    // write-one clears; reads never touch these flags
    assign abort_clr = (wr_fire && is_addr(aw_addr_reg, ADDR_STATUS) && w_strb_reg[1])
                       ? w_data_reg[STS_ABORT_LSB +: 3] : 3'h0;  // see [RQ9]

    // interrupt copies are separate so read-clear cannot hit the abort flags
    assign rd_hit_irq = is_addr(s_axi_araddr_i, ADDR_IRQ_STATUS);
    assign irq_clr    = (rd_fire && rd_hit_irq) ? 3'h7 : 3'h0;

    aicr_sticky #(
        .W (3)
    ) u_abort_flags (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .set_i      (events),
        .clr_i      (abort_clr),
        .flag_o     (abort_flags)
    );

    aicr_sticky #(
        .W (3)
    ) u_irq_flags (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .set_i      (events),
        .clr_i      (irq_clr),
        .flag_o     (irq_flags)
    );

    // level interrupt, one cycle behind the flags
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_flags & irq_mask_reg);
        end
    end

    // -------------------------------------------------------------
    // read channel
    // -------------------------------------------------------------
    assign rd_fire = s_axi_arvalid_i && arready_reg;

    // read mux; anything not decoded, reserved windows included, is zero
    always_comb begin
        rdata_next = 32'h0;  // see [RQ12] see [RQ17]
        if (is_addr(s_axi_araddr_i, ADDR_VENDOR_CODE)) begin
            rdata_next[15:0] = VENDOR_CODE;  // see [RQ1]
        end else if (is_addr(s_axi_araddr_i, ADDR_PART_CODE)) begin
            rdata_next[15:0] = PART_CODE;  // see [RQ2]
        end else if (is_addr(s_axi_araddr_i, ADDR_COMMAND)) begin
            rdata_next[15:0] = command_reg;
        end else if (is_addr(s_axi_araddr_i, ADDR_STATUS)) begin
            rdata_next[STS_SEL_LSB +: 2]   = SEL_TIMING_CODE;  // see [RQ5]
            rdata_next[STS_ABORT_LSB +: 3] = abort_flags;
        end else if (is_addr(s_axi_araddr_i, ADDR_HEADER)) begin
            rdata_next[7:0] = HEADER_FORMAT;  // see [RQ13]
        end else if (is_addr(s_axi_araddr_i, ADDR_PRIMARY_TIM)) begin
            rdata_next[15:0] = primary_reg;
        end else if (is_addr(s_axi_araddr_i, ADDR_SECONDARY)) begin
            rdata_next[3:0] = secondary_reg;
        end else if (rd_hit_irq) begin
            rdata_next[2:0] = irq_flags;
        end else if (is_addr(s_axi_araddr_i, ADDR_IRQ_MASK)) begin
            rdata_next[2:0] = irq_mask_reg;
        end
    end

    // data answers the cycle after the address is taken
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
        end else if (rd_fire) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rdata_next;
        end else if (rvalid_reg && s_axi_rready_i) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // drive timing decode
    // -------------------------------------------------------------
    // registered so the strobe generator sees clean settled settings
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            enable_reg <= 1'b0;
            decode_reg <= 1'b0;
            drive0_reg <= '0;
            drive1_reg <= '0;
        end else begin
            enable_reg <= command_reg[CMD_ENABLE_BIT];
            decode_reg <= primary_reg[PT_DECODE_BIT];
            drive0_reg.fast_bank     <= primary_reg[PT_FAST_BANK];
            drive0_reg.ready_en      <= primary_reg[PT_READY_EN];
            drive0_reg.prefetch_en   <= primary_reg[PT_PREFETCH];
            drive0_reg.compat_timing <= primary_reg[PT_COMPAT];
            drive0_reg.recovery_clks <= to_clks(RECOVERY_BASE,
                                        primary_reg[PT_RECOVERY_LSB +: 2]);  // see [RQ14]
            drive0_reg.sample_clks   <= to_clks(SAMPLE_BASE,
                                        primary_reg[PT_SAMPLE_LSB +: 2]);  // see [RQ15]
            drive1_reg.fast_bank     <= primary_reg[PT_DRIVE1_SHIFT + PT_FAST_BANK];
            drive1_reg.ready_en      <= primary_reg[PT_DRIVE1_SHIFT + PT_READY_EN];
            drive1_reg.prefetch_en   <= primary_reg[PT_DRIVE1_SHIFT + PT_PREFETCH];
            drive1_reg.compat_timing <= primary_reg[PT_DRIVE1_SHIFT + PT_COMPAT];
            if (primary_reg[PT_SPLIT_BIT]) begin  // see [RQ16]
                drive1_reg.recovery_clks <= to_clks(RECOVERY_BASE,
                                            secondary_reg[SEC_RECOVERY_LSB +: 2]);
                drive1_reg.sample_clks   <= to_clks(SAMPLE_BASE,
                                            secondary_reg[SEC_SAMPLE_LSB +: 2]);
            end else begin
                drive1_reg.recovery_clks <= to_clks(RECOVERY_BASE,
                                            primary_reg[PT_RECOVERY_LSB +: 2]);
                drive1_reg.sample_clks   <= to_clks(SAMPLE_BASE,
                                            primary_reg[PT_SAMPLE_LSB +: 2]);
            end
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign s_axi_awready_o    = awready_reg;
    assign s_axi_wready_o     = wready_reg;
    assign s_axi_bvalid_o     = bvalid_reg;
    assign s_axi_bresp_o      = AXI_RESP_OKAY;
    assign s_axi_arready_o    = arready_reg;
    assign s_axi_rvalid_o     = rvalid_reg;
    assign s_axi_rdata_o      = rdata_reg;
    assign s_axi_rresp_o      = AXI_RESP_OKAY;
    assign interface_enable_o = enable_reg;
    assign decode_enable_o    = decode_reg;
    assign drive0_timing_o    = drive0_reg;
    assign drive1_timing_o    = drive1_reg;
    assign irq_o              = irq_reg;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    property p_vendor_read;
        @(posedge core_clk_i) disable iff (srst_i)
        rd_fire && is_addr(s_axi_araddr_i, ADDR_VENDOR_CODE)
            |=> s_axi_rvalid_o && s_axi_rdata_o == {16'h0, VENDOR_CODE};
    endproperty
    a_vendor_read: assert property (p_vendor_read) else $error("vendor code misread"); // see [RQ1]

    property p_part_read;
        @(posedge core_clk_i) disable iff (srst_i)
        rd_fire && is_addr(s_axi_araddr_i, ADDR_PART_CODE)
            |=> s_axi_rdata_o[15:0] == PART_CODE;
    endproperty
    a_part_read: assert property (p_part_read) else $error("part code misread"); // see [RQ2]

    property p_sel_timing;
        @(posedge core_clk_i) disable iff (srst_i)
        rd_fire && is_addr(s_axi_araddr_i, ADDR_STATUS)
            |=> s_axi_rdata_o[10:9] == 2'b01 && s_axi_rdata_o[8:0] == 9'h0;
    endproperty
    a_sel_timing: assert property (p_sel_timing) else $error("select timing not 01"); // see [RQ5]

    property p_sig_abort;
        @(posedge core_clk_i) disable iff (srst_i)
        signaled_abort_i |=> abort_flags[0] && irq_flags[0];
    endproperty
    a_sig_abort: assert property (p_sig_abort) else $error("signaled abort lost"); // see [RQ6]

    property p_recv_abort;
        @(posedge core_clk_i) disable iff (srst_i)
        abort_in_i |=> abort_flags[1];
    endproperty
    a_recv_abort: assert property (p_recv_abort) else $error("received abort lost"); // see [RQ7]

    property p_master_abort;
        @(posedge core_clk_i) disable iff (srst_i)
        master_abort_i |=> abort_flags[2];
    endproperty
    a_master_abort: assert property (p_master_abort) else $error("master abort lost"); // see [RQ8]

    property p_read_keeps;
        @(posedge core_clk_i) disable iff (srst_i)
        rd_fire && is_addr(s_axi_araddr_i, ADDR_STATUS) && !wr_fire && events == 3'h0
            |=> abort_flags == $past(abort_flags);
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("read altered flags"); // see [RQ9]

    property p_w1c;
        @(posedge core_clk_i) disable iff (srst_i)
        wr_fire && is_addr(aw_addr_reg, ADDR_STATUS) && w_strb_reg[1]
            && w_data_reg[13] && !master_abort_i
            |=> !abort_flags[2] ##1 s_axi_bvalid_o || $past(s_axi_bready_i);
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear"); // see [RQ9]

    property p_reserved_zero;
        @(posedge core_clk_i) disable iff (srst_i)
        rd_fire && is_addr(s_axi_araddr_i, 12'h434)
            |=> s_axi_rdata_o == 32'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved not zero"); // see [RQ17]

    property p_split;
        @(posedge core_clk_i) disable iff (srst_i)
        primary_reg[PT_SPLIT_BIT] && $stable(secondary_reg) && $stable(primary_reg)
            |=> drive1_timing_o.recovery_clks == 3'h4 - {1'b0, $past(secondary_reg[1:0])}
                && drive0_timing_o.sample_clks == 3'h5 - {1'b0, $past(primary_reg[13:12])};
    endproperty
    a_split: assert property (p_split) else $error("split timing wrong"); // see [RQ16]

endmodule : aicr_regs

// ==== design/aicr_sticky.sv ====
module aicr_sticky
    import aicr_pkg::*;
#(
    parameter int W = 3
) (
    input  wire logic         core_clk_i,
    input  wire logic         srst_i,
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    output logic      [W-1:0] flag_o
);

    if (W < 1) begin : g_bad_w
        $error("aicr_sticky: W must be at least 1");
    end

    // set beats clear so an event in the clearing cycle survives
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            flag_o <= '0;
        end else begin
            flag_o <= (flag_o & ~clr_i) | set_i;
        end
    end

endmodule : aicr_sticky

// ==== testbench/aicr_host.sv ====
// processor side: one axi4-lite write or read at a time
// addresses are driven as given; the test also reaches 12'hffc, outside the configuration window
module aicr_host (
    input  wire logic        clk_i,
    output logic [11:0]      awaddr_o,
    output logic             awvalid_o,
    input  wire logic        awready_i,
    output logic [31:0]      wdata_o,
    output logic             wvalid_o,
    input  wire logic        wready_i,
    input  wire logic        bvalid_i,
    output logic             bready_o,
    output logic [11:0]      araddr_o,
    output logic             arvalid_o,
    input  wire logic        arready_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic        rvalid_i,
    output logic             rready_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
    end
    // each channel dropped only at the edge that takes it; no fixed latency assumed
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        awaddr_o <= a;
        wdata_o <= d;
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (awvalid_o && awready_i) awvalid_o <= 1'b0;
            if (wvalid_o && wready_i) wvalid_o <= 1'b0;
            if (bvalid_i) begin
                break;
            end
        end
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (arvalid_o && arready_i) arvalid_o <= 1'b0;
            if (rvalid_i) begin
                d = rdata_i;
                break;
            end
        end
    endtask : rd
endmodule : aicr_host

// ==== testbench/atapi_ide_config_registers_test.sv ====
module atapi_ide_config_registers_test import aicr_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] VC = 16'h5a5a;  // arbitrary value
    localparam logic [15:0] PC = 16'ha5a5;  // arbitrary value
    localparam logic [11:0] RA [5] = '{ADDR_VENDOR_CODE, ADDR_PART_CODE, ADDR_HEADER,
                                       12'h434, 12'hffc};
    localparam logic [31:0] RE [5] = '{32'(VC), 32'(PC), 32'(HEADER_FORMAT), '0, '0};
    logic clk_i, srst, awvalid_o, awready_i, wvalid_o, wready_i, bvalid_i, bready_o;
    logic arvalid_o, arready_i, rvalid_i, rready_o, en, irq, dec;
    logic [11:0] awaddr_o, araddr_o;
    logic [31:0] wdata_o, rdata_i;
    logic [2:0] ev;
    aicr_drive_t d0, d1;
    int failures, check_count, cyc;
    aicr_host h (.*);
    aicr_regs #(.VENDOR_CODE(VC), .PART_CODE(PC)) DUT (
        .core_clk_i(clk_i), .srst_i(srst),
        .s_axi_awaddr_i(awaddr_o), .s_axi_awvalid_i(awvalid_o), .s_axi_awready_o(awready_i),
        .s_axi_wdata_i(wdata_o), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid_o),
        .s_axi_wready_o(wready_i), .s_axi_bresp_o(), .s_axi_bvalid_o(bvalid_i),
        .s_axi_bready_i(bready_o), .s_axi_araddr_i(araddr_o), .s_axi_arvalid_i(arvalid_o),
        .s_axi_arready_o(arready_i), .s_axi_rdata_o(rdata_i), .s_axi_rresp_o(),
        .s_axi_rvalid_o(rvalid_i), .s_axi_rready_i(rready_o), .signaled_abort_i(ev[0]),
        .abort_in_i(ev[1]), .master_abort_i(ev[2]), .interface_enable_o(en),
        .decode_enable_o(dec), .drive0_timing_o(d0), .drive1_timing_o(d1), .irq_o(irq));
    // ----------------
    // checking helpers
    // ----------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("FAIL %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        h.rd(a, r);
        chk(r, e);
    endtask : rdchk
    task automatic settle;
        @(posedge clk_i);
        #1;
    endtask : settle
    task automatic end_of_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // read-only, reserved and unmapped words shrug off an all-ones write
    task automatic t_ident;
        for (int i = 0; i < 5; i++) begin
            h.wr(RA[i], 32'hffff);
            rdchk(RA[i], RE[i]);
        end
    endtask : t_ident
    // each abort sets its flag; read keeps it, write 0 keeps, write 1 clears
    task automatic t_abort;
        h.wr(ADDR_IRQ_MASK, 32'h6);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            ev[i] <= 1'b1;
            @(posedge clk_i);
            ev[i] <= 1'b0;
            repeat (2) settle;
            chk(irq, 32'(i != 0));
            rdchk(ADDR_STATUS, 32'h0200 | (1 << (11 + i)));
            rdchk(ADDR_STATUS, 32'h0200 | (1 << (11 + i)));
            h.wr(ADDR_STATUS, 32'h0200);
            rdchk(ADDR_STATUS, 32'h0200 | (1 << (11 + i)));
            h.wr(ADDR_STATUS, 32'h0200 | (1 << (11 + i)));
            rdchk(ADDR_STATUS, 32'h0200);
            rdchk(ADDR_IRQ_STATUS, 32'(1 << i));
            rdchk(ADDR_IRQ_STATUS, 32'h0);
            settle;
            chk(irq, 32'h0);
        end
    endtask : t_abort
    // every recovery and sample code, then split timing for drive 1
    task automatic t_timing;
        for (int c = 0; c < 4; c++) begin
            h.wr(ADDR_PRIMARY_TIM, 32'(c * 'h1100));
            settle;
            chk({d0.sample_clks, d0.recovery_clks}, 32'(44 - 9 * c));
            chk({d1.sample_clks, d1.recovery_clks}, 32'(44 - 9 * c));
        end
        h.wr(ADDR_SECONDARY, 32'h7);
        h.wr(ADDR_PRIMARY_TIM, 32'h4000);
        settle;
        chk({d0.sample_clks, d0.recovery_clks}, 32'd44);
        chk({d1.sample_clks, d1.recovery_clks}, 32'd33);
        // drive flags and decode enable pass straight through
        h.wr(ADDR_PRIMARY_TIM, 32'hc0ff);
        settle;
        chk({dec, d0, d1}, {11'h7ec, 10'h3e1});
        rdchk(ADDR_PRIMARY_TIM, 32'hc0ff);
    endtask : t_timing
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_of_test;
        end
    end
    initial begin
        {srst, ev, failures, check_count, cyc} = {1'b1, 3'h0, 32'h0, 32'h0, 32'h0};
        repeat (6) @(posedge clk_i);
        srst <= 1'b0;
        settle;
        rdchk(ADDR_COMMAND, 32'h0);
        h.wr(ADDR_COMMAND, 32'h1);
        settle;
        chk(en, 32'h1);
        t_ident;
        t_abort;
        t_timing;
        end_of_test;
    end
endmodule : atapi_ide_config_registers_test
